//--- core/gpcb_defs.svh
// register indices, field positions, reset values for the gpio pin config bank
// How it works
// - bit 0 sets direction, 1 input
// - bit 1 set inverts pin value
// - bit 7 open-drain, bits 3:2 function, bits 6:4 reserved
// - pin 4.2 bit 2 routes power event
// - power event drives active low uninverted
// - pin 4.3: 11 edge irq, 01 strap control
// - strap mode forces input, no inversion
// - strap field 01 ignores further writes
// - any of three resets clears strap field
// - strap pin high: disable register read-only
// - strap pin low: disable register writable
// - pin 5.0 code 01 ring indicate input
// - pin 5.5 code 01 request-to-send output
// - pin 5.6 code 01 clear-to-send input
// - pin 5.7 code 01 terminal-ready output
// - pin 6.0: 10 edge irq, 01 indicator
// - all config registers reset to 0x01
`ifndef GPCB_DEFS_SVH
`define GPCB_DEFS_SVH
// register indices, byte address is four times the index
`define GPCB_IDX_PIN_4_2 8'h3D
`define GPCB_IDX_PIN_4_3 8'h3E
`define GPCB_IDX_PIN_5_0 8'h3F
`define GPCB_IDX_PIN_5_5 8'h44
`define GPCB_IDX_PIN_5_6 8'h45
`define GPCB_IDX_PIN_5_7 8'h46
`define GPCB_IDX_PIN_6_0 8'h47
`define GPCB_IDX_PIN_DATA 8'h60
`define GPCB_IDX_PIN_LEVEL 8'h61
`define GPCB_IDX_IRQ_STATUS 8'h62
`define GPCB_IDX_IRQ_MASK 8'h63
`define GPCB_IDX_DEV_DISABLE 8'h64
// reset values
`define GPCB_CFG_RESET 8'h01
`define GPCB_DISABLE_RESET 8'h00
// function codes
`define GPCB_FN_GPIO 2'h0
`define GPCB_FN_ALT1 2'h1
`define GPCB_FN_ALT2 2'h2
`define GPCB_FN_ALT3 2'h3
// pin slots in the bank
`define GPCB_SLOT_4_2 0
`define GPCB_SLOT_4_3 1
`define GPCB_SLOT_5_0 2
`define GPCB_SLOT_5_5 3
`define GPCB_SLOT_5_6 4
`define GPCB_SLOT_5_7 5
`define GPCB_SLOT_6_0 6
// status bit positions
`define GPCB_IRQ_BIT_3 0
`define GPCB_IRQ_BIT_4 1
`endif

//--- core/gpcb_pkg.sv
// types shared by the gpio pin config bank
package gpcb_pkg;
    // one pin configuration byte
    typedef struct packed {
        logic       open_drain; // bit 7
        logic [2:0] rsvd;       // bits 6:4
        logic [1:0] func;       // bits 3:2 (bit 2 only on pin 4.2)
        logic       invert;     // bit 1
        logic       is_input;   // bit 0
    } gpcb_cfg_t;
    // captured ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } gpcb_aphase_t;
    // per-pin effective setup after function overrides
    typedef struct packed {
        logic is_input;
        logic invert;
        logic use_alt;
        logic alt_val;
        logic open_drain;
    } gpcb_pinmode_t;
endpackage : gpcb_pkg

//--- core/gpcb_top.sv
// gpio pin config bank: seven pin config registers, ahb-lite slave, pin muxing
`timescale 1ns/1ns
`default_nettype none
`include "gpcb_defs.svh"
module gpcb_top
    import gpcb_pkg::*;
#(
    parameter int NPINS = 7
) (
    // clock and resets
    input wire logic ref_clk_i,
    input wire logic reset_i,           // standby power-on reset
    input wire logic main_por_i,        // main power-on reset
    input wire logic hard_reset_i,      // hard reset
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // pins, order 4.2 4.3 5.0 5.5 5.6 5.7 6.0
    input wire logic [NPINS-1:0] pin_in_i,
    output logic [NPINS-1:0] pin_out_o,
    output logic [NPINS-1:0] pin_oe_o,
    // alternate function sources and sinks
    input wire logic power_event_i,               // active high event request
    input wire logic port2_request_to_send_n_i,
    input wire logic port2_terminal_ready_n_i,
    input wire logic indicator_out_first_i,
    output logic port2_ring_indicate_n_o,
    output logic port2_clear_to_send_n_o,
    // device-disable register and interrupt
    output logic [7:0] disable_reg_o,
    output logic irq_o
);
    // all storage is plain flops; the bank is too small for a memory
    // macro to pay for its wiring
    // register state
    gpcb_cfg_t cfg_ff [NPINS];          // pin config registers
    logic [NPINS-1:0] data_ff;          // gpio output values
    logic [1:0] irq_status_ff;          // sticky edge events
    logic [1:0] irq_mask_ff;            // 1 lets the event through
    logic [7:0] disable_ff;             // device-disable register
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic irq_ff;
    gpcb_aphase_t aphase_ff;            // pending data phase
    // pins count as synchronous but still pass two flops, so a slow
    // board edge never reaches the status logic half settled
    // pin side state
    logic [NPINS-1:0] sync1_ff;         // first synchroniser stage only
    logic [NPINS-1:0] sync2_ff;         // safe level
    logic [NPINS-1:0] sync3_ff;         // delayed copy for edges
    logic [NPINS-1:0] pin_out_ff;
    logic [NPINS-1:0] pin_oe_ff;
    logic ring_ff;
    logic cts_ff;
    // decoded views of the registers, recomputed every cycle
    // combinational
    gpcb_pinmode_t mode [NPINS];
    logic [NPINS-1:0] level;            // pin value seen by logic
    logic [1:0] irq_event;
    logic strap_sel;
    logic strap_locked;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_status;

    // every port is a register copy, so board timing sees no logic
    // cone behind an output
    // outputs come straight from flops
    assign hrdata_o = hrdata_ff;
    assign hreadyout_o = hreadyout_ff;
    assign hresp_o = hresp_ff;
    assign pin_out_o = pin_out_ff;
    assign pin_oe_o = pin_oe_ff;
    assign port2_ring_indicate_n_o = ring_ff;
    assign port2_clear_to_send_n_o = cts_ff;
    assign disable_reg_o = disable_ff;
    assign irq_o = irq_ff;

    // only the low byte of a word holds a register; byte lanes and
    // hsize are not decoded, so a narrow write acts as a word write
    // bus decode: write lands in the data phase, read data is latched in the address phase
    assign wr_en = aphase_ff.valid & aphase_ff.write;
    assign rd_en = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
    assign wbyte = hwdata_i[7:0];

    // the config indices are not contiguous, so a compare chain is
    // cheaper than a subtraction and a range check
    // slot lookup for a register index, returns NPINS when not a config register
    function automatic int cfg_slot(input logic [7:0] idx);
        int s;
        s = NPINS;
        case (idx)
            `GPCB_IDX_PIN_4_2: s = `GPCB_SLOT_4_2;
            `GPCB_IDX_PIN_4_3: s = `GPCB_SLOT_4_3;
            `GPCB_IDX_PIN_5_0: s = `GPCB_SLOT_5_0;
            `GPCB_IDX_PIN_5_5: s = `GPCB_SLOT_5_5;
            `GPCB_IDX_PIN_5_6: s = `GPCB_SLOT_5_6;
            `GPCB_IDX_PIN_5_7: s = `GPCB_SLOT_5_7;
            `GPCB_IDX_PIN_6_0: s = `GPCB_SLOT_6_0;
            default: s = NPINS;
        endcase
        return s;
    endfunction : cfg_slot

    // the write lands one cycle later, when hwdata stands; a read is
    // answered from the live address phase instead
    // address phase capture, only word singles are expected
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            aphase_ff <= '0;
        end else if (hready_i) begin
            aphase_ff.valid <= hsel_i & htrans_i[1];
            aphase_ff.write <= hwrite_i;
            // upper address bits must be zero, else the access is unmapped
            aphase_ff.index <= (haddr_i[31:10] == 22'h0) ? haddr_i[9:2] : 8'hFF;
        end
    end

    // kept as flops although constant, so a later wait state stays
    // a local change
    // zero wait states, always okay
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    // decoded from the live address phase, so the answer is in place
    // when the data phase begins
    // read mux, unmapped and reserved bits read zero
    always_comb begin
        int s;
        s = cfg_slot(haddr_i[9:2]);
        nxt_rdata = 32'h0;
        if (haddr_i[31:10] != 22'h0) begin
            nxt_rdata = 32'h0;
        end else if (s < NPINS) begin
            nxt_rdata[7:0] = cfg_ff[s];
        end else begin
            case (haddr_i[9:2])
                `GPCB_IDX_PIN_DATA: nxt_rdata[NPINS-1:0] = data_ff;
                `GPCB_IDX_PIN_LEVEL: nxt_rdata[NPINS-1:0] = level;
                `GPCB_IDX_IRQ_STATUS: nxt_rdata[1:0] = irq_status_ff;
                `GPCB_IDX_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
                `GPCB_IDX_DEV_DISABLE: nxt_rdata[7:0] = disable_ff;
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    // read data register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            hrdata_ff <= 32'h0;
        end else if (rd_en) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // pin 4.2 has a one-bit function field; its upper bit stays zero
    // so it reads back as reserved
    // the lock tests the stored field: the write that selects strap
    // control still lands, every later change of the field is refused
    // config registers; reserved bits are held at zero
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NPINS; i++) begin
                cfg_ff[i] <= gpcb_cfg_t'(`GPCB_CFG_RESET);
            end
        end else begin
            if (wr_en && cfg_slot(aphase_ff.index) < NPINS) begin
                for (int i = 0; i < NPINS; i++) begin
                    if (cfg_slot(aphase_ff.index) == i) begin
                        cfg_ff[i].is_input <= wbyte[0];
                        cfg_ff[i].invert <= wbyte[1];
                        cfg_ff[i].open_drain <= wbyte[7];
                        if (i == `GPCB_SLOT_4_2) begin
                            cfg_ff[i].func <= {1'b0, wbyte[2]};
                        end else if (i != `GPCB_SLOT_4_3
                                     || cfg_ff[i].func != `GPCB_FN_ALT1) begin
                            cfg_ff[i].func <= wbyte[3:2];
                        end
                    end
                end
            end
            // main or hard reset releases the strap lock, beats any write
            if (main_por_i || hard_reset_i) begin
                cfg_ff[`GPCB_SLOT_4_3].func <= `GPCB_FN_GPIO;
            end
        end
    end

    // bit order follows the pin slots, the top bit reads zero
    // gpio output data, an own register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            data_ff <= '0;
        end else if (wr_en && aphase_ff.index == `GPCB_IDX_PIN_DATA) begin
            data_ff <= wbyte[NPINS-1:0];
        end
    end

    // the lock trails the pin by the synchroniser delay; a write
    // within two cycles of a pin change still sees the old level
    // strap control of the device-disable register
    assign strap_sel = (cfg_ff[`GPCB_SLOT_4_3].func == `GPCB_FN_ALT1);
    // raw synchronised level: polarity is forced off in this mode
    assign strap_locked = strap_sel & sync2_ff[`GPCB_SLOT_4_3];

    // only the standby reset clears it; main and hard reset leave it
    // alone and only release the strap selection
    // device-disable register, writable unless the strap locks it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            disable_ff <= `GPCB_DISABLE_RESET;
        end else if (wr_en && aphase_ff.index == `GPCB_IDX_DEV_DISABLE && !strap_locked) begin
            disable_ff <= wbyte;
        end
    end

    // alternate outputs keep the direction bit, so software must
    // clear bit 0 as well; polarity applies to them too
    // per-pin effective mode after the alternate function overrides
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            mode[i].is_input = cfg_ff[i].is_input;
            mode[i].invert = cfg_ff[i].invert;
            mode[i].open_drain = cfg_ff[i].open_drain;
            mode[i].use_alt = 1'b0;
            mode[i].alt_val = 1'b0;
        end
        // power event out: active low before polarity, so uninverted gives low
        if (cfg_ff[`GPCB_SLOT_4_2].func[0]) begin
            mode[`GPCB_SLOT_4_2].use_alt = 1'b1;
            mode[`GPCB_SLOT_4_2].alt_val = ~power_event_i;
        end
        // strap mode ignores direction and polarity bits
        if (strap_sel) begin
            mode[`GPCB_SLOT_4_3].is_input = 1'b1;
            mode[`GPCB_SLOT_4_3].invert = 1'b0;
        end
        // request-to-send and terminal-ready driven from the second serial port
        if (cfg_ff[`GPCB_SLOT_5_5].func == `GPCB_FN_ALT1) begin
            mode[`GPCB_SLOT_5_5].use_alt = 1'b1;
            mode[`GPCB_SLOT_5_5].alt_val = port2_request_to_send_n_i;
        end
        if (cfg_ff[`GPCB_SLOT_5_7].func == `GPCB_FN_ALT1) begin
            mode[`GPCB_SLOT_5_7].use_alt = 1'b1;
            mode[`GPCB_SLOT_5_7].alt_val = port2_terminal_ready_n_i;
        end
        // indicator output
        if (cfg_ff[`GPCB_SLOT_6_0].func == `GPCB_FN_ALT1) begin
            mode[`GPCB_SLOT_6_0].use_alt = 1'b1;
            mode[`GPCB_SLOT_6_0].alt_val = indicator_out_first_i;
        end
    end

    // level carries polarity so software reads the logical value;
    // the edge logic uses the raw level, so inversion never hides
    // an edge
    // pin slices: synchroniser and output driver, one per pin
    for (genvar g = 0; g < NPINS; g++) begin : g_pin
        logic drive_lvl; // value at the pin when driven
        assign drive_lvl = (mode[g].use_alt ? mode[g].alt_val : data_ff[g]) ^ mode[g].invert;
        assign level[g] = sync2_ff[g] ^ mode[g].invert;

        // two-stage synchroniser plus a third stage for edge detection
        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                sync1_ff[g] <= 1'b0;
                sync2_ff[g] <= 1'b0;
                sync3_ff[g] <= 1'b0;
            end else begin
                sync1_ff[g] <= pin_in_i[g];
                sync2_ff[g] <= sync1_ff[g];
                sync3_ff[g] <= sync2_ff[g];
            end
        end

        // open-drain never drives high; the board pull supplies it
        // driver: input floats, open-drain only pulls low, push-pull drives both
        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                pin_out_ff[g] <= 1'b0;
                pin_oe_ff[g] <= 1'b0;
            end else if (mode[g].is_input) begin
                pin_out_ff[g] <= 1'b0;
                pin_oe_ff[g] <= 1'b0;
            end else if (mode[g].open_drain) begin
                pin_out_ff[g] <= 1'b0;
                pin_oe_ff[g] <= ~drive_lvl;
            end else begin
                pin_out_ff[g] <= drive_lvl;
                pin_oe_ff[g] <= 1'b1;
            end
        end
    end

    // a routed input follows polarity like any other; unrouted, the
    // port sees its inactive level, so no false ring is reported
    // serial port inputs; idle high when the pin is not routed
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ring_ff <= 1'b1;
            cts_ff <= 1'b1;
        end else begin
            ring_ff <= (cfg_ff[`GPCB_SLOT_5_0].func == `GPCB_FN_ALT1)
                       ? level[`GPCB_SLOT_5_0] : 1'b1;
            cts_ff <= (cfg_ff[`GPCB_SLOT_5_6].func == `GPCB_FN_ALT1)
                      ? level[`GPCB_SLOT_5_6] : 1'b1;
        end
    end

    // the third stage trails the second by one edge, so a change is
    // flagged once; the false edge after reset is harmless because
    // reset also returns both pins to plain gpio
    // either-edge events on the synchronised level, both directions
    always_comb begin
        irq_event = 2'b00;
        irq_event[`GPCB_IRQ_BIT_3] = (cfg_ff[`GPCB_SLOT_4_3].func == `GPCB_FN_ALT3)
            && (sync2_ff[`GPCB_SLOT_4_3] != sync3_ff[`GPCB_SLOT_4_3]);
        irq_event[`GPCB_IRQ_BIT_4] = (cfg_ff[`GPCB_SLOT_6_0].func == `GPCB_FN_ALT2)
            && (sync2_ff[`GPCB_SLOT_6_0] != sync3_ff[`GPCB_SLOT_6_0]);
    end

    // the clear comes from the data phase, the set from the live
    // event; when both meet the event survives and no edge is lost
    // sticky status, write one to clear; a same-cycle event wins
    always_comb begin
        nxt_status = irq_status_ff;
        if (wr_en && aphase_ff.index == `GPCB_IDX_IRQ_STATUS) begin
            nxt_status = nxt_status & ~wbyte[1:0];
        end
        nxt_status = nxt_status | irq_event;
    end

    // the mask only gates the interrupt; status records every event
    // status and mask registers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_status_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
        end else begin
            irq_status_ff <= nxt_status;
            if (wr_en && aphase_ff.index == `GPCB_IDX_IRQ_MASK) begin
                irq_mask_ff <= wbyte[1:0];
            end
        end
    end

    // registered so the pin is glitch free, at one cycle of latency
    // level interrupt, one cycle behind the status
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end
endmodule : gpcb_top
`default_nettype wire

//--- tb/gpcb_board.sv
// board model: pull levels behind the seven pins, resolved against the bank's drive
`timescale 1ns/1ns
`default_nettype none
module gpcb_board (
    // drive from the bank
    input wire logic [6:0] pin_out_i,
    input wire logic [6:0] pin_oe_i,
    // level the board holds on an undriven pin
    input wire logic [6:0] pull_i,
    // resolved wire level
    output logic [6:0] pin_o
);
    // released or open-drain-off pins float to the pull level
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & pull_i);
endmodule : gpcb_board
`default_nettype wire

//--- tb/gpcb_properties.sv
// port checker for the gpio pin config bank
`timescale 1ns/1ns
`default_nettype none
`include "gpcb_defs.svh"
module gpcb_props #(
    parameter int NPINS = 7
) (
    // clock and resets
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic main_por_i,
    input wire logic hard_reset_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // pins and status
    input wire logic [NPINS-1:0] pin_in_i,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic [7:0] disable_reg_o,
    input wire logic irq_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    logic take; // address phase accepted
    logic cfg_rd; // read of a config slot
    logic wr_ff; // mapped write data phase
    logic [7:0] idx_ff; // its index
    logic lock_ff; // strap control selected
    logic dis_wr; // disable register written now
    assign take = hsel_i && htrans_i[1] && hready_i;
    assign cfg_rd = take && !hwrite_i && haddr_i[31:10] == 22'h0
        && (haddr_i[9:2] inside {[8'h3D:8'h3F], [8'h44:8'h47]});
    assign dis_wr = wr_ff && idx_ff == `GPCB_IDX_DEV_DISABLE;
    // shadow of the strap latch; only the three resets undo it
    always_ff @(posedge ref_clk_i) begin
        wr_ff <= !reset_i && take && hwrite_i && haddr_i[31:10] == 22'h0;
        idx_ff <= haddr_i[9:2];
        if (reset_i || main_por_i || hard_reset_i) begin
            lock_ff <= 1'b0;
        end else if (wr_ff && idx_ff == `GPCB_IDX_PIN_4_3 && hwdata_i[3:2] == 2'h1) begin
            lock_ff <= 1'b1;
        end
    end
    reset_idle_a: assert property ($fell(reset_i) |-> pin_oe_o == '0 && !irq_o)
        else $error("pin driven or irq after reset");
    strap_input_a: assert property (lock_ff |=> !pin_oe_o[1])
        else $error("strap pin driven");
    strap_ro_a: assert property ((lock_ff && pin_in_i[1]) [*4] |=> $stable(disable_reg_o))
        else $error("disable register changed while locked");
    strap_rw_a: assert property ((lock_ff && !pin_in_i[1]) [*4] ##0 dis_wr
        |=> disable_reg_o == $past(hwdata_i[7:0])) else $error("disable write lost");
    open_wr_a: assert property (!lock_ff && dis_wr |=> disable_reg_o == $past(hwdata_i[7:0]))
        else $error("unlocked disable write lost");
    cfg_rsvd_a: assert property (cfg_rd |=> hrdata_o[31:8] == 24'h0 && hrdata_o[6:4] == 3'h0)
        else $error("reserved config bits read nonzero");
    unmapped_rd_a: assert property (take && !hwrite_i && haddr_i[31:10] != 22'h0
        |=> hrdata_o == 32'h0) else $error("unmapped read nonzero");
    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or error");
    cover property (lock_ff && dis_wr);
    cover property (irq_o);
    cover property (cfg_rd);
endmodule : gpcb_props
bind gpcb_top gpcb_props #(.NPINS(NPINS)) u_props (.ref_clk_i, .reset_i, .main_por_i,
    .hard_reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .pin_in_i, .pin_oe_o, .disable_reg_o, .irq_o);
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the gpio pin config bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic [2:0] rv = 3'h1; // standby, main, hard reset
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [6:0] pull = 7'h7F; // board levels, all high
    logic pme = 1'b0;
    logic rts = 1'b1;
    logic dtr = 1'b1;
    logic led = 1'b0;
    logic [31:0] hrdata, rd;
    logic [6:0] pin_in, pin_out, pin_oe;
    logic hready, hresp, ri_n, cts_n, irq;
    logic [7:0] dis;
    int num_errors = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    gpcb_top #(.NPINS(7)) u_dut (.ref_clk_i(clk), .reset_i(rv[0]), .main_por_i(rv[1]),
        .hard_reset_i(rv[2]), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .pin_in_i(pin_in),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe), .power_event_i(pme),
        .port2_request_to_send_n_i(rts), .port2_terminal_ready_n_i(dtr),
        .indicator_out_first_i(led), .port2_ring_indicate_n_o(ri_n),
        .port2_clear_to_send_n_o(cts_n), .disable_reg_o(dis), .irq_o(irq));
    gpcb_board u_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pull_i(pull), .pin_o(pin_in));
    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // bounded wait for ready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : wait_rdy
    // one single word transfer; read data taken at the data phase's end
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, {22'h0, i, 2'h0}, {24'h0, d});
    endtask : wr
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        xfer(1'b0, {22'h0, i, 2'h0}, 32'h0);
        chk(rd, {24'h0, e});
    endtask : rc
    // settle n edges, then sample mid-cycle
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : look
    // write a config and judge one pin's enable and value
    task automatic wp(input logic [7:0] i, input logic [7:0] d, input int k, input logic [1:0] e);
        wr(i, d);
        look(2);
        chk({pin_oe[k], pin_out[k]}, e);
    endtask : wp
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        rv <= m;
        @(posedge clk);
        rv <= 3'h0;
    endtask : pulse
    task automatic s_reset();
        logic [7:0] cfg [7] = '{8'h3D, 8'h3E, 8'h3F, 8'h44, 8'h45, 8'h46, 8'h47};
        foreach (cfg[k]) begin
            rc(cfg[k], 8'h01);
        end
        wr(8'h70, 8'h5A);
        rc(8'h70, 8'h00);
        xfer(1'b0, 32'h0000_10F4, 32'h0);
        chk(rd, 32'h0);
    endtask : s_reset
    task automatic s_gpio();
        wr(8'h60, 8'h01);
        wp(8'h3D, 8'h00, 0, 2'h3);
        wp(8'h3D, 8'h02, 0, 2'h2);
        wp(8'h3D, 8'h80, 0, 2'h0);
        wp(8'h60, 8'h00, 0, 2'h2);
        wp(8'h3D, 8'h03, 0, 2'h0);
        wr(8'h44, 8'h75);
        rc(8'h44, 8'h05);
        @(posedge clk);
        pme <= 1'b1;
        wp(8'h3D, 8'h04, 0, 2'h2);
        wp(8'h3D, 8'h84, 0, 2'h2);
        @(posedge clk);
        pme <= 1'b0;
        wp(8'h3D, 8'h84, 0, 2'h0);
        wp(8'h3D, 8'h04, 0, 2'h3);
    endtask : s_gpio
    task automatic s_serial();
        wr(8'h3F, 8'h05);
        wr(8'h45, 8'h05);
        wr(8'h44, 8'h04);
        wr(8'h46, 8'h04);
        wr(8'h47, 8'h04);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            pull <= v ? 7'h7F : 7'h6B;
            rts <= v[0];
            dtr <= !v[0];
            led <= v[0];
            look(3);
            chk(ri_n, v[0]);
            chk(cts_n, v[0]);
            chk(pin_out[3], v[0]);
            chk(pin_out[5], !v[0]);
            chk(pin_out[6], v[0]);
        end
    endtask : s_serial
    task automatic s_irq();
        wr(8'h63, 8'h03);
        wr(8'h3E, 8'h0D);
        wr(8'h47, 8'h09);
        look(4);
        wr(8'h62, 8'h03);
        rc(8'h62, 8'h00);
        @(posedge clk);
        pull[1] <= 1'b0;
        look(5);
        rc(8'h62, 8'h01);
        chk(irq, 1'b1);
        wr(8'h63, 8'h00);
        look(2);
        chk(irq, 1'b0);
        wr(8'h62, 8'h01);
        wr(8'h63, 8'h03);
        @(posedge clk);
        pull[1] <= 1'b1;
        look(5);
        rc(8'h62, 8'h01);
        wr(8'h62, 8'h01);
        @(posedge clk);
        pull[6] <= 1'b0;
        look(5);
        rc(8'h62, 8'h02);
        wr(8'h62, 8'h02);
        look(2);
        chk(irq, 1'b0);
        wr(8'h3E, 8'h01);
    endtask : s_irq
    task automatic s_strap();
        wp(8'h3E, 8'h06, 1, 2'h0);
        wr(8'h3E, 8'h0C);
        rc(8'h3E, 8'h04);
        wr(8'h64, 8'h5A);
        rc(8'h64, 8'h00);
        @(posedge clk);
        pull[1] <= 1'b0;
        look(3);
        wr(8'h64, 8'h5A);
        rc(8'h64, 8'h5A);
        chk(dis, 8'h5A);
        @(posedge clk);
        pull[1] <= 1'b1;
        look(3);
        wr(8'h64, 8'hA5);
        rc(8'h64, 8'h5A);
        chk(dis, 8'h5A);
        pulse(3'h2);
        rc(8'h3E, 8'h00);
        wr(8'h3E, 8'h04);
        pulse(3'h4);
        rc(8'h3E, 8'h00);
        wr(8'h64, 8'h77);
        rc(8'h64, 8'h77);
        wr(8'h3E, 8'h04);
        pulse(3'h1);
        rc(8'h3E, 8'h01);
    endtask : s_strap
    initial begin
        repeat (8) @(posedge clk);
        rv <= 3'h0;
        s_reset();
        s_gpio();
        s_serial();
        s_irq();
        s_strap();
        tally_and_finish();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
